/* File: pkg/jbs_pkg.sv */
package jbs_pkg;

  // ------------------------------------------------------------
  // register sizes
  // ------------------------------------------------------------
  localparam int IR_W  = 8;
  localparam int ID_W  = 32;
  localparam int BSR_W = 113;

  // ------------------------------------------------------------
  // instruction encodings
  // ------------------------------------------------------------
  localparam logic [7:0] INS_EXTEST  = 8'h00;
  localparam logic [7:0] INS_IDCODE  = 8'h21;
  localparam logic [7:0] INS_SAMPLE  = 8'h05;
  localparam logic [7:0] INS_CLAMP   = 8'h07;
  localparam logic [7:0] INS_HIGHZ   = 8'h03;
  localparam logic [7:0] INS_BYPASS  = 8'hff;
  localparam logic [1:0] IR_CAPTURE  = 2'h1;

  // ------------------------------------------------------------
  // identification fields (values arbitrary, not a real maker)
  // ------------------------------------------------------------
  localparam logic [3:0]  ID_REVISION = 4'h1;
  localparam logic [15:0] ID_PART     = 16'h1234;
  localparam logic [10:0] ID_VENDOR   = 11'h055;
  localparam logic [31:0] ID_VALUE    = {ID_REVISION, ID_PART, ID_VENDOR, 1'b1};

  // ------------------------------------------------------------
  // controller states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR,
    ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } jbs_state_type;

endpackage

/* File: pkg/jbs_ctl_if.sv */
`timescale 1ns/1ps
interface jbs_ctl_if;
  logic                    tck_rise;
  logic                    tck_fall;
  logic                    tms;
  jbs_pkg::jbs_state_type  state;

  modport fsm  (input tck_rise, input tms, output state);
  modport user (input tck_rise, input tck_fall, input state);
endinterface

/* File: hdl/jbs_edge.sv */
`timescale 1ns/1ps
// two-stage sync of tck/tms/tdi, then edge detection of tck
module jbs_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // raw pins
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  // synced outputs
  output logic      tck_rise,
  output logic      tck_fall,
  output logic      tms_s,
  output logic      tdi_s
);
  logic [2:0] tck_reg;
  logic [1:0] tms_reg;
  logic [1:0] tdi_reg;

  // first stage read only by second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_reg <= 3'h0;
      tms_reg <= 2'h3;
      tdi_reg <= 2'h3;
    end else begin
      tck_reg <= {tck_reg[1:0], tck};
      tms_reg <= {tms_reg[0], tms};
      tdi_reg <= {tdi_reg[0], tdi};
    end
  end

  assign tck_rise = tck_reg[1] & ~tck_reg[2];
  assign tck_fall = ~tck_reg[1] & tck_reg[2];
  assign tms_s    = tms_reg[1];
  assign tdi_s    = tdi_reg[1];
endmodule

/* File: hdl/jbs_fsm.sv */
`timescale 1ns/1ps
// tap controller state graph
module jbs_fsm (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // control carrier
  jbs_ctl_if.fsm    ctl
);
  jbs_pkg::jbs_state_type state_reg;
  jbs_pkg::jbs_state_type state_next;

  // standard sixteen-state graph, advanced on tck rise only
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      jbs_pkg::ST_RESET:    state_next = ctl.tms ? jbs_pkg::ST_RESET : jbs_pkg::ST_IDLE;
      jbs_pkg::ST_IDLE:     state_next = ctl.tms ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
      jbs_pkg::ST_SEL_DR:   state_next = ctl.tms ? jbs_pkg::ST_SEL_IR : jbs_pkg::ST_CAP_DR;
      jbs_pkg::ST_CAP_DR:   state_next = ctl.tms ? jbs_pkg::ST_EXIT1_DR : jbs_pkg::ST_SHIFT_DR;
      jbs_pkg::ST_SHIFT_DR: state_next = ctl.tms ? jbs_pkg::ST_EXIT1_DR : jbs_pkg::ST_SHIFT_DR;
      jbs_pkg::ST_EXIT1_DR: state_next = ctl.tms ? jbs_pkg::ST_UPD_DR : jbs_pkg::ST_PAUSE_DR;
      jbs_pkg::ST_PAUSE_DR: state_next = ctl.tms ? jbs_pkg::ST_EXIT2_DR : jbs_pkg::ST_PAUSE_DR;
      jbs_pkg::ST_EXIT2_DR: state_next = ctl.tms ? jbs_pkg::ST_UPD_DR : jbs_pkg::ST_SHIFT_DR;
      jbs_pkg::ST_UPD_DR:   state_next = ctl.tms ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
      jbs_pkg::ST_SEL_IR:   state_next = ctl.tms ? jbs_pkg::ST_RESET : jbs_pkg::ST_CAP_IR;
      jbs_pkg::ST_CAP_IR:   state_next = ctl.tms ? jbs_pkg::ST_EXIT1_IR : jbs_pkg::ST_SHIFT_IR;
      jbs_pkg::ST_SHIFT_IR: state_next = ctl.tms ? jbs_pkg::ST_EXIT1_IR : jbs_pkg::ST_SHIFT_IR;
      jbs_pkg::ST_EXIT1_IR: state_next = ctl.tms ? jbs_pkg::ST_UPD_IR : jbs_pkg::ST_PAUSE_IR;
      jbs_pkg::ST_PAUSE_IR: state_next = ctl.tms ? jbs_pkg::ST_EXIT2_IR : jbs_pkg::ST_PAUSE_IR;
      jbs_pkg::ST_EXIT2_IR: state_next = ctl.tms ? jbs_pkg::ST_UPD_IR : jbs_pkg::ST_SHIFT_IR;
      jbs_pkg::ST_UPD_IR:   state_next = ctl.tms ? jbs_pkg::ST_SEL_DR : jbs_pkg::ST_IDLE;
    endcase
  end

  // power-up lands in test-logic-reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= jbs_pkg::ST_RESET;
    end else if (ctl.tck_rise) begin
      state_reg <= state_next;
    end
  end

  assign ctl.state = state_reg;
endmodule

/* File: hdl/jbs_tap.sv */
`timescale 1ns/1ps
// Summary of operation
// - tdo driven only in shift-ir/shift-dr
// - sample on tck rise, tdo on fall
// - shift in at msb, out at lsb
// - five tms highs reach test-logic-reset
// - idle holds on tms low, branches onward
// - select-dr-scan leaves data registers untouched
// - capture-dr parallel-loads selected register
// - shift-dr moves one bit per tck
// - exit1/pause/exit2 paths as standard
// - extest outputs change only in update-dr
// - instruction shifts in, applies at update-ir
// - tap reset never disturbs memory operation
// - power-up reset floats tdo
// - ir loads idcode at power-up and reset
// - capture-ir loads binary 01 into lsbs
// - one-bit bypass, captured as zero
// - 113-bit boundary register, captures i/o ring
// - idcode loads hardwired 32-bit code
// - extest drives vector from update-ir on
// - high-z floats all i/o ring outputs; tdo still drives in shift
// - clamp drives held boundary values
// - sample captures ball levels for shifting
// - extest, idcode, sample encodings
// - clamp, high-z, bypass select bypass
// - id layout revision, part, vendor, one
module jbs_tap (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  // test pins
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  output logic                           tdo_o,
  output logic                           tdo_oe,
  // i/o ring
  input  wire logic [jbs_pkg::BSR_W-1:0] ring_in,
  output logic      [jbs_pkg::BSR_W-1:0] ring_out,
  output logic                           ring_test_en,
  output logic                           ring_highz
);
  // ------------------------------------------------------------
  // synchronisers and controller
  // ------------------------------------------------------------
  logic tck_rise;
  logic tck_fall;
  logic tms_s;
  logic tdi_s;

  jbs_ctl_if ctl ();

  jbs_edge u_edge (
    .clk      (clk),
    .rst_b    (rst_b),
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi),
    .tck_rise (tck_rise),
    .tck_fall (tck_fall),
    .tms_s    (tms_s),
    .tdi_s    (tdi_s)
  );

  assign ctl.tck_rise = tck_rise;
  assign ctl.tck_fall = tck_fall;
  assign ctl.tms      = tms_s;

  jbs_fsm u_fsm (
    .clk   (clk),
    .rst_b (rst_b),
    .ctl   (ctl)
  );

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [jbs_pkg::IR_W-1:0]  ir_shift_reg;
  logic [jbs_pkg::IR_W-1:0]  ir_reg;
  logic                      byp_reg;
  logic [jbs_pkg::ID_W-1:0]  id_reg;
  logic [jbs_pkg::BSR_W-1:0] bsr_reg;
  logic [jbs_pkg::BSR_W-1:0] upd_reg;
  logic                      tdo_reg;
  logic                      oe_reg;
  logic                      test_en_reg;
  logic                      highz_reg;

  // instruction decode for path select; pin control compares ir_reg directly
  function automatic logic uses_bsr(input logic [7:0] ins);
    uses_bsr = (ins == jbs_pkg::INS_EXTEST) || (ins == jbs_pkg::INS_SAMPLE);
  endfunction

  function automatic logic uses_id(input logic [7:0] ins);
    uses_id = (ins == jbs_pkg::INS_IDCODE);
  endfunction

  logic  rise_st;
  jbs_pkg::jbs_state_type st;
  assign st      = ctl.state;
  assign rise_st = tck_rise;

  // ------------------------------------------------------------
  // state and path decode
  // ------------------------------------------------------------
  logic cap_dr;
  logic shift_dr;
  logic upd_dr;
  logic cap_ir;
  logic shift_ir;
  logic upd_ir;
  logic in_tlr;
  logic in_shift;
  logic sel_bsr;
  logic sel_id;

  // one-clk strobes: a state qualified by the tck rise that leaves it
  assign cap_dr   = rise_st && (st == jbs_pkg::ST_CAP_DR);
  assign shift_dr = rise_st && (st == jbs_pkg::ST_SHIFT_DR);
  assign upd_dr   = rise_st && (st == jbs_pkg::ST_UPD_DR);
  assign cap_ir   = rise_st && (st == jbs_pkg::ST_CAP_IR);
  assign shift_ir = rise_st && (st == jbs_pkg::ST_SHIFT_IR);
  assign upd_ir   = rise_st && (st == jbs_pkg::ST_UPD_IR);
  assign in_tlr   = rise_st && (st == jbs_pkg::ST_RESET);

  // levels: tdo drive window and the path of the active instruction
  assign in_shift = (st == jbs_pkg::ST_SHIFT_IR) || (st == jbs_pkg::ST_SHIFT_DR);
  assign sel_bsr  = uses_bsr(ir_reg);
  assign sel_id   = uses_id(ir_reg);

  // ------------------------------------------------------------
  // instruction register
  // ------------------------------------------------------------
  // shift stage; reserved codes later fall to bypass
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_shift_reg <= jbs_pkg::INS_IDCODE;
    end else if (cap_ir) begin
      ir_shift_reg <= {ir_shift_reg[jbs_pkg::IR_W-1:2], jbs_pkg::IR_CAPTURE};
    end else if (shift_ir) begin
      ir_shift_reg <= {tdi_s, ir_shift_reg[jbs_pkg::IR_W-1:1]};
    end
  end

  // active instruction: idcode at power-up and on test-logic-reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_reg <= jbs_pkg::INS_IDCODE;
    end else if (in_tlr) begin
      ir_reg <= jbs_pkg::INS_IDCODE;
    end else if (upd_ir) begin
      ir_reg <= ir_shift_reg;
    end
  end

  // ------------------------------------------------------------
  // bypass and identification registers
  // ------------------------------------------------------------
  // bypass bit captured as zero, so a broken chain shows up as a stuck bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      byp_reg <= 1'b0;
    end else if (cap_dr && !sel_bsr && !sel_id) begin
      byp_reg <= 1'b0;
    end else if (shift_dr && !sel_bsr && !sel_id) begin
      byp_reg <= tdi_s;
    end
  end

  // identification: hardwired code reloaded on every capture under idcode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      id_reg <= jbs_pkg::ID_VALUE;
    end else if (cap_dr && sel_id) begin
      id_reg <= jbs_pkg::ID_VALUE;
    end else if (shift_dr && sel_id) begin
      id_reg <= {tdi_s, id_reg[jbs_pkg::ID_W-1:1]};
    end
  end

  // ------------------------------------------------------------
  // boundary cells
  // ------------------------------------------------------------
  logic [jbs_pkg::BSR_W:0] bsr_chain;

  // tdi enters at the msb end, each cell feeds its lower neighbour
  assign bsr_chain = {tdi_s, bsr_reg};

  for (genvar i = 0; i < jbs_pkg::BSR_W; i++) begin : g_cell
    // capture and shift stage; holds elsewhere, select-dr included
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        bsr_reg[i] <= 1'b0;
      end else if (cap_dr && sel_bsr) begin
        bsr_reg[i] <= ring_in[i];
      end else if (shift_dr && sel_bsr) begin
        bsr_reg[i] <= bsr_chain[i+1];
      end
    end

    // update stage: ball-side value moves only in update-dr
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        upd_reg[i] <= 1'b0;
      end else if (upd_dr && sel_bsr) begin
        upd_reg[i] <= bsr_reg[i];
      end
    end
  end

  // ------------------------------------------------------------
  // ball control
  // ------------------------------------------------------------
  // balls take the update latch under extest and clamp; memory keeps running
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      test_en_reg <= 1'b0;
    end else begin
      test_en_reg <= (ir_reg == jbs_pkg::INS_EXTEST)
                     || (ir_reg == jbs_pkg::INS_CLAMP);
    end
  end

  // high-z floats every ball while bypass carries the serial path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      highz_reg <= 1'b0;
    end else begin
      highz_reg <= (ir_reg == jbs_pkg::INS_HIGHZ);
    end
  end

  // ------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------
  // drive enable follows the state seen at each tck fall
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oe_reg <= 1'b0;
    end else if (tck_fall) begin
      oe_reg <= in_shift;
    end
  end

  // tdo launched on tck fall, from the lsb of the selected path
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo_reg <= 1'b0;
    end else if (tck_fall) begin
      if (st == jbs_pkg::ST_SHIFT_IR) begin
        tdo_reg <= ir_shift_reg[0];
      end else if (sel_bsr) begin
        tdo_reg <= bsr_reg[0];
      end else if (sel_id) begin
        tdo_reg <= id_reg[0];
      end else begin
        tdo_reg <= byp_reg;
      end
    end
  end

  assign tdo_o        = tdo_reg;
  assign tdo_oe       = oe_reg;
  assign ring_out     = upd_reg;
  assign ring_test_en = test_en_reg;
  assign ring_highz   = highz_reg;
endmodule

/* File: verification/jbs_tap_assertions.sv */
`timescale 1ns/1ps
module jbs_tap_assertions (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst_b,
  // test pins
  input wire logic                      tck,
  input wire logic                      tms,
  input wire logic                      tdi,
  input wire logic                      tdo_o,
  input wire logic                      tdo_oe,
  // i/o ring
  input wire logic [jbs_pkg::BSR_W-1:0] ring_in,
  input wire logic [jbs_pkg::BSR_W-1:0] ring_out,
  input wire logic                      ring_test_en,
  input wire logic                      ring_highz
);
  // ----
  // edge bookkeeping
  // ----
  logic       tck_q;
  logic [3:0] sf;
  logic [3:0] sr;
  logic       lt;
  logic       lp;
  logic [2:0] hc;
  // clk cycles since raw tck fell/rose, saturating; tms at the last two rises
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_q <= 1'b0;
      sf    <= 4'hf;
      sr    <= 4'hf;
      lt    <= 1'b0;
      lp    <= 1'b0;
      hc    <= 3'h0;
    end else begin
      tck_q <= tck;
      sf    <= (tck_q && !tck) ? 4'h0 : (sf == 4'hf) ? sf : sf + 4'h1;
      sr    <= (!tck_q && tck) ? 4'h0 : (sr == 4'hf) ? sr : sr + 4'h1;
      if (!tck_q && tck) begin
        lt <= tms;
        lp <= lt;
        hc <= !tms ? 3'h0 : (hc == 3'h7) ? hc : hc + 3'h1;
      end
    end
  end
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // sync delay puts the change at sf 2; the window allows one cycle early and three late
  sequence s_fall_win; sf inside {[1:5]}; endsequence
  // update states are entered with tms high, one rise before the one that acts
  sequence s_upd_win; sr inside {[1:6]} && lp; endsequence
  sequence s_quiet; !tdo_oe [*3]; endsequence
  property p_oe_edge; $changed(tdo_oe) |-> s_fall_win; endproperty
  property p_do_edge; tdo_oe && $changed(tdo_o) |-> s_fall_win; endproperty
  // looked at after the fall has settled and before the next rise is seen
  property p_oe_shift; tdo_oe && sf == 4'h4 |-> !lt; endproperty
  property p_ring_upd; $changed(ring_out) |-> s_upd_win; endproperty
  property p_test_en; $changed(ring_test_en) |-> s_upd_win; endproperty
  property p_highz; $changed(ring_highz) |-> s_upd_win; endproperty
  property p_excl; !(ring_test_en && ring_highz); endproperty
  property p_tlr; hc >= 3'h5 && sr == 4'h8 |-> !tdo_oe && !ring_test_en && !ring_highz;
  endproperty
  property p_rst; $rose(rst_b) |-> s_quiet; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("tdo_oe moved off a tck fall");
  a_do_edge: assert property (p_do_edge) else $error("tdo_o moved off a tck fall");
  a_oe_shift: assert property (p_oe_shift) else $error("tdo driven outside shift");
  a_ring_upd: assert property (p_ring_upd) else $error("ring_out moved off update");
  a_test_en: assert property (p_test_en) else $error("test_en moved off update");
  a_highz: assert property (p_highz) else $error("highz moved off update");
  a_excl: assert property (p_excl) else $error("clamp and highz together");
  a_tlr: assert property (p_tlr) else $error("test logic active in reset");
  a_rst: assert property (p_rst) else $error("tdo driven after reset");
endmodule
bind jbs_tap jbs_tap_assertions u_chk (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
  .ring_test_en(ring_test_en), .ring_highz(ring_highz));

/* File: verification/jbs_tester.sv */
`timescale 1ns/1ps
module jbs_tester (
  // clock
  input  wire logic clk,
  // test pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_o,
  input  wire logic tdo_oe
);
  logic ph;
  // tck stands low between frames; tms and tdi rest at pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    ph  = 1'b0;
  end
  // one tck period: set tms/tdi, read tdo just before the rise
  task automatic step(input logic m, input logic d, output logic q, output logic oe);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    repeat (2) @(posedge clk);
    q  = tdo_o;
    oe = tdo_oe;
    tck <= 1'b1;
    repeat (6) @(posedge clk);
    tck <= 1'b0;
    repeat (3 + int'(ph)) @(posedge clk); // 12/13 cycles: 125 ns mean
    ph = ~ph;
  endtask
endmodule

/* File: verification/jbs_tap_bench.sv */
`timescale 1ns/1ps
module jbs_tap_bench;
  logic                      clk;
  logic                      rst_b;
  logic                      tck;
  logic                      tms;
  logic                      tdi;
  logic                      tdo_o;
  logic                      tdo_oe;
  logic [jbs_pkg::BSR_W-1:0] ring_in;
  logic [jbs_pkg::BSR_W-1:0] ring_out;
  logic                      ring_test_en;
  logic                      ring_highz;
  logic [127:0]              d;
  logic [127:0]              v;
  logic [7:0]                codes [4];
  int                        err_count = 0;
  int                        check_count = 0;
  int                        cyc = 0;
  jbs_tap DUT (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out), .ring_test_en(ring_test_en),
    .ring_highz(ring_highz));
  jbs_tester u_tst (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard: the run needs under 10000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      stop_test();
    end
  end
  // ----
  // model and helpers
  // ----
  // serial stream of a len-bit path: captured bits, then tdi delayed by len
  function automatic logic [127:0] mdl(int len, logic [127:0] cap, logic [127:0] din, int n);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < n; i++) r[i] = (i < len) ? cap[i] : din[i - len];
    return r;
  endfunction
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // idle to idle through one scan; optional pause after bit pk
  task automatic scan(input bit ir, input int n, input logic [127:0] din, input int pk,
                      output logic [127:0] dout);
    logic q;
    logic oe;
    dout = '0;
    u_tst.step(1'b1, 1'b1, q, oe);
    if (ir) u_tst.step(1'b1, 1'b1, q, oe);
    u_tst.step(1'b0, 1'b1, q, oe);
    u_tst.step(1'b0, 1'b1, q, oe);
    for (int i = 0; i < n; i++) begin
      u_tst.step(i == n - 1 || i == pk, din[i], dout[i], oe);
      chk(128'(oe), 128'(1));
      if (i == pk) begin
        u_tst.step(1'b0, 1'b1, q, oe);
        u_tst.step(1'b1, 1'b1, q, oe);
        u_tst.step(1'b0, 1'b1, q, oe);
        chk(128'(oe), 128'(0));
      end
    end
    u_tst.step(1'b1, 1'b1, q, oe);
    chk(128'(oe), 128'(0));
    u_tst.step(1'b0, 1'b1, q, oe);
  endtask
  task automatic stop_test();
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    rst_b = 1'b0;
    ring_in = '0;
    codes = '{jbs_pkg::INS_BYPASS, jbs_pkg::INS_CLAMP, jbs_pkg::INS_HIGHZ, 8'h5a};
    v = 128'($urandom(32'h062b014c));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    u_tst.step(1'b0, 1'b1, d[0], d[1]);
    scan(0, 40, v, 5, d);
    chk(d, mdl(32, 128'(jbs_pkg::ID_VALUE), v, 40));
    for (int k = 0; k < 4; k++) begin
      scan(1, 8, 128'(codes[k]), -1, d);
      chk(128'(d[1:0]), 128'(jbs_pkg::IR_CAPTURE));
      v = {$urandom, $urandom, $urandom, $urandom};
      scan(0, 16, v, -1, d);
      chk(d, mdl(1, 128'(0), v, 16));
      chk(128'({ring_test_en, ring_highz}), 128'({k == 1, k == 2}));
    end
    // sample then preload, read back through the update latch
    v = {$urandom, $urandom, $urandom, $urandom};
    ring_in <= v[112:0];
    scan(1, 8, 128'(jbs_pkg::INS_SAMPLE), -1, d);
    v = {$urandom, $urandom, $urandom, $urandom};
    scan(0, 120, v, -1, d);
    chk(d, mdl(113, 128'(ring_in), v, 120));
    chk(128'(ring_out), 128'(v[119:7]));
    ring_in <= ~ring_in;
    scan(1, 8, 128'(jbs_pkg::INS_EXTEST), -1, d);
    chk(128'({ring_test_en, ring_out}), 128'({1'b1, v[119:7]}));
    v = {$urandom, $urandom, $urandom, $urandom};
    scan(0, 113, v, -1, d);
    chk(d, mdl(113, 128'(ring_in), v, 113));
    chk(128'(ring_out), 128'(v[112:0]));
    // five tms highs, then identity again
    repeat (5) u_tst.step(1'b1, 1'b1, d[0], d[1]);
    u_tst.step(1'b0, 1'b1, d[0], d[1]);
    chk(128'({ring_test_en, ring_highz}), 128'(0));
    scan(0, 32, v, -1, d);
    chk(d, mdl(32, 128'(jbs_pkg::ID_VALUE), v, 32));
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(128'({tdo_oe, ring_test_en, ring_out}), 128'(0));
    stop_test();
  end
endmodule
